// >>> hw/sora_pkg.sv
package sora_pkg;
    // serial frame
    localparam int FRAME_W = 16;
    localparam int ADDR_W  = 7;
    localparam int WR_BIT  = 15;
    localparam int ADDR_LSB = 8;
    localparam int BYTE_W  = 8;

    // register byte addresses (lower byte)
    localparam logic [6:0] OFF_SUPPLY = 7'h02;
    localparam logic [6:0] OFF_ACC_X  = 7'h04;
    localparam logic [6:0] OFF_ACC_Y  = 7'h06;
    localparam logic [6:0] OFF_ACC_Z  = 7'h08;
    localparam logic [6:0] OFF_AUX    = 7'h0a;
    localparam logic [6:0] OFF_TEMP   = 7'h0c;
    localparam logic [6:0] OFF_PEAK_X = 7'h0e;
    localparam logic [6:0] OFF_PEAK_Y = 7'h10;
    localparam logic [6:0] OFF_PEAK_Z = 7'h12;
    localparam logic [6:0] OFF_SUMSQ  = 7'h14;
    localparam logic [6:0] OFF_DIAG   = 7'h1a;
    localparam logic [6:0] OFF_THR1   = 7'h38;
    localparam logic [6:0] OFF_THR2   = 7'h3a;
    localparam logic [6:0] OFF_ALM    = 7'h3c;
    localparam logic [6:0] OFF_MISC   = 7'h46;
    localparam logic [6:0] OFF_GCMD   = 7'h4a;

    // result slots, in address order
    localparam logic [3:0] RES_SUPPLY = 4'h0;
    localparam logic [3:0] RES_ACC_X  = 4'h1;
    localparam logic [3:0] RES_AUX    = 4'h4;
    localparam logic [3:0] RES_TEMP   = 4'h5;
    localparam logic [3:0] RES_PEAK_X = 4'h6;
    localparam logic [3:0] RES_SUMSQ  = 4'h9;
    localparam logic [3:0] RES_NONE   = 4'hf;
    localparam int         RES_NUM    = 10;
    localparam int         AXES       = 3;

    // output word layout
    localparam int ND_BIT      = 15;
    localparam int EA_BIT      = 14;
    localparam int SAMPLE_W    = 10;
    localparam int SUMSQ_W     = 12;
    localparam int SUMSQ_SHIFT = 8;
    localparam int SQ_W        = 22;

    // control bits
    localparam int MISC_DRDY_BIT  = 2;
    localparam int MISC_PEAK_BIT  = 14;
    localparam int MISC_SUMSQ_BIT = 15;
    localparam int GCMD_PCLR_BIT  = 5;
    localparam int ALM_DIR_BIT    = 15;
    localparam int ALM_MAG_W      = 14;
    localparam int ALM_SRC_LSB    = 8;
    localparam int ALM_SRC_W      = 4;
    localparam int ALM_CAP_LSB    = 4;
    localparam int ALM_IND_EN     = 2;
    localparam int ALM_IND_POL    = 1;
    localparam int ALM_IND_PIN    = 0;
    localparam int ALARMS         = 2;

    // alarm source codes
    localparam logic [3:0] SRC_OFF  = 4'h0;
    localparam logic [3:0] SRC_SUP  = 4'h1;
    localparam logic [3:0] SRC_ACCX = 4'h2;
    localparam logic [3:0] SRC_ACCZ = 4'h4;
    localparam logic [3:0] SRC_AUX  = 4'h5;
    localparam logic [3:0] SRC_TEMP = 4'h6;
    localparam logic [3:0] SRC_SUMSQ = 4'h7;
    localparam logic [3:0] SRC_EXT  = 4'h8;

    // reset values
    localparam logic [15:0] THR_RST  = 16'h9000;
    localparam logic [15:0] ALM_RST  = 16'h0000;
    localparam logic [15:0] MISC_RST = 16'h0006;

    // capture memory
    localparam int CAPT_DEPTH = 8192;
    localparam int CAPT_W     = 8;
    localparam int CAPT_LSB   = 2;
    localparam int CAPT_LEN   = 256;
endpackage

// >>> hw/sora_regs.sv
// What this block does
// - reading a result clears its new flag
// - fresh sample sets the new flag again
// - data-ready pacing forces new flag high
// - error flag mirrors any diagnostic error
// - supply result: 10-bit unsigned code
// - acceleration: 10-bit two's complement
// - temperature result: 10-bit unsigned code
// - peak registers keep largest axis magnitude
// - combined peak: scaled sum of squares
// - command bit 5 clears all peaks
// - alarm source selected by control nibbles
// - threshold bit 15 picks compare direction
// - threshold magnitude in bits 13 to 0
// - alarm enable bits start event capture
// - indicator enable, polarity and line select
// - three 8192 by 8-bit capture banks
// - read needs command frame then data frame
// - register spans even and odd byte
module sora_regs #(
    parameter int unsigned CAPT_DEPTH = sora_pkg::CAPT_DEPTH,
    parameter int unsigned CAPT_LEN   = sora_pkg::CAPT_LEN
) (
    // clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      rstn_i,
    // serial pins
    input  wire logic                      spi_sclk_i,
    input  wire logic                      spi_cs_n_i,
    input  wire logic                      spi_din_i,
    output logic                           spi_dout_o,
    output logic                           spi_dout_oe_n_o,
    // internal samples
    input  wire logic                      sample_valid_i,
    input  wire logic [9:0]                supply_i,
    input  wire logic [9:0]                accel_x_i,
    input  wire logic [9:0]                accel_y_i,
    input  wire logic [9:0]                accel_z_i,
    input  wire logic [9:0]                aux_i,
    input  wire logic [9:0]                temp_i,
    input  wire logic [15:0]               diag_error_flags_i,
    input  wire logic                      ext_trigger_i,
    // capture read port
    input  wire logic [$clog2(CAPT_DEPTH)-1:0] capt_rd_addr_i,
    output logic [7:0]                     capt_x_o,
    output logic [7:0]                     capt_y_o,
    output logic [7:0]                     capt_z_o,
    // alarm outputs
    output logic                           gen_io_line_a_o,
    output logic                           gen_io_line_b_o,
    output logic                           capture_start_o
);
    localparam int PW = $clog2(CAPT_DEPTH);

    logic        frame_valid;
    logic [15:0] frame_word;
    logic [15:0] tx_word;
    logic        wr_stb;
    logic        rd_stb;
    logic [6:0]  addr;
    logic [7:0]  wdata;
    logic [3:0]  rd_idx;
    logic        peak_clr;

    logic [11:0] res_data [sora_pkg::RES_NUM];
    logic [sora_pkg::RES_NUM-1:0] nd;
    logic [sora_pkg::RES_NUM-1:0] upd;
    logic [9:0]  next_pk [sora_pkg::AXES];
    logic [9:0]  new_acc [sora_pkg::AXES];
    logic [21:0] sq_sum;
    logic [11:0] sumsq_sat;

    logic [15:0] thr [sora_pkg::ALARMS];
    logic [15:0] alarm_control;
    logic [15:0] misc_control_reg;
    logic [1:0]  alarm_act;
    logic [1:0]  next_alarm;
    logic [3:0]  sel;
    logic [13:0] mag;
    logic        hit;
    logic        sample_seen;

    logic [7:0]    mem_x [CAPT_DEPTH];
    logic [7:0]    mem_y [CAPT_DEPTH];
    logic [7:0]    mem_z [CAPT_DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW:0]   cap_left;

    sora_spi_slave u_spi (
        .clk_sys_i       (clk_sys_i),
        .rstn_i          (rstn_i),
        .spi_sclk_i      (spi_sclk_i),
        .spi_cs_n_i      (spi_cs_n_i),
        .spi_din_i       (spi_din_i),
        .spi_dout_o      (spi_dout_o),
        .spi_dout_oe_n_o (spi_dout_oe_n_o),
        .tx_word_i       (tx_word),
        .frame_valid_o   (frame_valid),
        .frame_word_o    (frame_word)
    );

    function automatic logic [6:0] word_of(input logic [6:0] a);
        word_of = {a[6:1], 1'b0};
    endfunction

    function automatic logic [3:0] res_index(input logic [6:0] a);
        logic [6:0] w;
        w = word_of(a);
        res_index = sora_pkg::RES_NONE;
        if (w >= sora_pkg::OFF_SUPPLY && w <= sora_pkg::OFF_SUMSQ) begin
            res_index = 4'(w[6:1] - 6'h01);
        end
    endfunction

    function automatic logic [9:0] mag10(input logic [9:0] v);
        mag10 = v[9] ? 10'(-v) : v;
    endfunction

    function automatic logic [15:0] put_byte(input logic [15:0] old, input logic [6:0] a,
                                             input logic [7:0] d);
        put_byte = old;
        if (a[0]) begin
            put_byte[15:8] = d;
        end else begin
            put_byte[7:0] = d;
        end
    endfunction

    function automatic logic [15:0] read_word(input logic [6:0] a);
        logic [3:0] idx;
        idx = res_index(a);
        read_word = '0;
        if (idx != sora_pkg::RES_NONE) begin
            read_word[11:0] = res_data[idx];
            read_word[sora_pkg::ND_BIT] = nd[idx] | misc_control_reg[sora_pkg::MISC_DRDY_BIT];
            read_word[sora_pkg::EA_BIT] = |diag_error_flags_i;
        end else begin
            unique case (word_of(a))
                sora_pkg::OFF_DIAG: read_word = diag_error_flags_i;
                sora_pkg::OFF_THR1: read_word = thr[0];
                sora_pkg::OFF_THR2: read_word = thr[1];
                sora_pkg::OFF_ALM:  read_word = alarm_control;
                sora_pkg::OFF_MISC: read_word = misc_control_reg;
                default:            read_word = '0;
            endcase
        end
    endfunction

    assign addr     = frame_word[sora_pkg::WR_BIT-1:sora_pkg::ADDR_LSB];
    assign wdata    = frame_word[sora_pkg::BYTE_W-1:0];
    assign wr_stb   = frame_valid & frame_word[sora_pkg::WR_BIT];
    assign rd_stb   = frame_valid & ~frame_word[sora_pkg::WR_BIT];
    assign rd_idx   = res_index(addr);
    assign peak_clr = wr_stb && addr == sora_pkg::OFF_GCMD && wdata[sora_pkg::GCMD_PCLR_BIT];

    // answer to a read goes out on the following frame
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_word <= '0;
        end else if (frame_valid) begin
            tx_word <= rd_stb ? read_word(addr) : '0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            thr[0]           <= sora_pkg::THR_RST;
            thr[1]           <= sora_pkg::THR_RST;
            alarm_control    <= sora_pkg::ALM_RST;
            misc_control_reg <= sora_pkg::MISC_RST;
        end else if (wr_stb) begin
            unique case (word_of(addr))
                sora_pkg::OFF_THR1: thr[0] <= put_byte(thr[0], addr, wdata);
                sora_pkg::OFF_THR2: thr[1] <= put_byte(thr[1], addr, wdata);
                sora_pkg::OFF_ALM:  alarm_control <= put_byte(alarm_control, addr, wdata);
                sora_pkg::OFF_MISC: misc_control_reg <= put_byte(misc_control_reg, addr, wdata);
                default: ;
            endcase
        end
    end

    // peak tracking and sum of squares
    assign new_acc[0] = accel_x_i;
    assign new_acc[1] = accel_y_i;
    assign new_acc[2] = accel_z_i;

    always_comb begin
        sq_sum = '0;
        for (int i = 0; i < sora_pkg::AXES; i++) begin
            next_pk[i] = res_data[sora_pkg::RES_PEAK_X+i][9:0];
            if (misc_control_reg[sora_pkg::MISC_PEAK_BIT] &&
                mag10(new_acc[i]) > mag10(next_pk[i])) begin
                next_pk[i] = new_acc[i];
            end
            sq_sum = sq_sum + 22'($signed(next_pk[i]) * $signed(next_pk[i]));
        end
        sumsq_sat = |sq_sum[sora_pkg::SQ_W-1:sora_pkg::SUMSQ_W+sora_pkg::SUMSQ_SHIFT] ? '1 :
                    sq_sum[sora_pkg::SUMSQ_W+sora_pkg::SUMSQ_SHIFT-1:sora_pkg::SUMSQ_SHIFT];
    end

    always_comb begin
        upd = '0;
        if (sample_valid_i) begin
            upd[sora_pkg::RES_PEAK_X-1:0] = '1;
            for (int i = 0; i < sora_pkg::AXES; i++) begin
                upd[sora_pkg::RES_PEAK_X+i] = misc_control_reg[sora_pkg::MISC_PEAK_BIT];
            end
            upd[sora_pkg::RES_SUMSQ] = misc_control_reg[sora_pkg::MISC_SUMSQ_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < sora_pkg::RES_NUM; i++) begin
                res_data[i] <= '0;
            end
        end else begin
            if (sample_valid_i) begin
                res_data[sora_pkg::RES_SUPPLY] <= {2'h0, supply_i};
                for (int i = 0; i < sora_pkg::AXES; i++) begin
                    res_data[sora_pkg::RES_ACC_X+i] <= {2'h0, new_acc[i]};
                end
                res_data[sora_pkg::RES_AUX]  <= {2'h0, aux_i};
                res_data[sora_pkg::RES_TEMP] <= {2'h0, temp_i};
            end
            for (int i = 0; i < sora_pkg::AXES; i++) begin
                if (peak_clr) begin
                    res_data[sora_pkg::RES_PEAK_X+i] <= '0;
                end else if (upd[sora_pkg::RES_PEAK_X+i]) begin
                    res_data[sora_pkg::RES_PEAK_X+i] <= {2'h0, next_pk[i]};
                end
            end
            if (peak_clr) begin
                res_data[sora_pkg::RES_SUMSQ] <= '0;
            end else if (upd[sora_pkg::RES_SUMSQ]) begin
                res_data[sora_pkg::RES_SUMSQ] <= sumsq_sat;
            end
        end
    end

    // new-data flags: a fresh sample beats a read in the same cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nd <= '0;
        end else begin
            for (int i = 0; i < sora_pkg::RES_NUM; i++) begin
                if (upd[i]) begin
                    nd[i] <= 1'b1;
                end else if (rd_stb && rd_idx == 4'(i)) begin
                    nd[i] <= 1'b0;
                end
            end
        end
    end

    // alarms: sampled sources judged the cycle after their registers load, external trigger every cycle
    always_comb begin
        sel = '0;
        mag = '0;
        hit = 1'b0;
        for (int i = 0; i < sora_pkg::ALARMS; i++) begin
            sel = alarm_control[sora_pkg::ALM_SRC_LSB+i*sora_pkg::ALM_SRC_W +: sora_pkg::ALM_SRC_W];
            if (sel >= sora_pkg::SRC_ACCX && sel <= sora_pkg::SRC_ACCZ) begin
                mag = 14'(mag10(res_data[sel-sora_pkg::SRC_SUP][9:0]));
            end else if (sel >= sora_pkg::SRC_SUP && sel <= sora_pkg::SRC_SUMSQ) begin
                mag = 14'(res_data[sel == sora_pkg::SRC_SUMSQ ? sora_pkg::RES_SUMSQ : sel-sora_pkg::SRC_SUP]);
            end
            hit = thr[i][sora_pkg::ALM_DIR_BIT] ? (mag > thr[i][sora_pkg::ALM_MAG_W-1:0]) :
                                                  (mag < thr[i][sora_pkg::ALM_MAG_W-1:0]);
            next_alarm[i] = alarm_act[i];
            if (sel == sora_pkg::SRC_EXT) begin
                next_alarm[i] = ext_trigger_i;
            end else if (sel == sora_pkg::SRC_OFF || sel > sora_pkg::SRC_EXT) begin
                next_alarm[i] = 1'b0;
            end else if (sample_seen) begin
                next_alarm[i] = hit;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_seen     <= 1'b0;
            alarm_act       <= '0;
            capture_start_o <= 1'b0;
            gen_io_line_a_o <= 1'b0;
            gen_io_line_b_o <= 1'b0;
        end else begin
            sample_seen     <= sample_valid_i;
            alarm_act       <= next_alarm;
            capture_start_o <= |(next_alarm & ~alarm_act &
                                 alarm_control[sora_pkg::ALM_CAP_LSB +: sora_pkg::ALARMS]);
            gen_io_line_a_o <= alarm_control[sora_pkg::ALM_IND_EN] & ~alarm_control[sora_pkg::ALM_IND_PIN] &
                               ~(|next_alarm ^ alarm_control[sora_pkg::ALM_IND_POL]);
            gen_io_line_b_o <= alarm_control[sora_pkg::ALM_IND_EN] & alarm_control[sora_pkg::ALM_IND_PIN] &
                               ~(|next_alarm ^ alarm_control[sora_pkg::ALM_IND_POL]);
        end
    end

    // capture banks, one per axis
    always_ff @(posedge clk_sys_i) begin
        if (sample_valid_i && cap_left != '0) begin
            mem_x[wr_ptr] <= accel_x_i[9:sora_pkg::CAPT_LSB];
            mem_y[wr_ptr] <= accel_y_i[9:sora_pkg::CAPT_LSB];
            mem_z[wr_ptr] <= accel_z_i[9:sora_pkg::CAPT_LSB];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr   <= '0;
            cap_left <= '0;
            capt_x_o <= '0;
            capt_y_o <= '0;
            capt_z_o <= '0;
        end else begin
            capt_x_o <= mem_x[capt_rd_addr_i];
            capt_y_o <= mem_y[capt_rd_addr_i];
            capt_z_o <= mem_z[capt_rd_addr_i];
            if (capture_start_o) begin
                cap_left <= (PW+1)'(CAPT_LEN);
            end else if (sample_valid_i && cap_left != '0) begin
                cap_left <= cap_left - 1'b1;
                wr_ptr   <= wr_ptr + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    a_nd_read_clear: assert property (rd_stb && rd_idx == sora_pkg::RES_ACC_X && !sample_valid_i
        |=> !nd[sora_pkg::RES_ACC_X]) else $error("new flag not cleared by read");
    a_nd_sample_set: assert property (sample_valid_i |=> nd[sora_pkg::RES_TEMP] ##1
        (nd[sora_pkg::RES_TEMP] || $past(rd_stb))) else $error("new flag not set by sample");
    a_nd_drdy_high: assert property (rd_stb && rd_idx != sora_pkg::RES_NONE &&
        misc_control_reg[sora_pkg::MISC_DRDY_BIT] |=> tx_word[sora_pkg::ND_BIT])
        else $error("new flag low in data-ready mode");
    a_ea_mirror: assert property (rd_stb && rd_idx != sora_pkg::RES_NONE |=>
        tx_word[sora_pkg::EA_BIT] == |$past(diag_error_flags_i)) else $error("error flag wrong");
    a_peak_keeps_max: assert property (sample_valid_i && !peak_clr &&
        misc_control_reg[sora_pkg::MISC_PEAK_BIT] |=>
        mag10(res_data[sora_pkg::RES_PEAK_X][9:0]) >= mag10($past(accel_x_i)))
        else $error("peak lost a larger sample");
    a_peak_clear: assert property (peak_clr |=> res_data[sora_pkg::RES_PEAK_X] == '0 &&
        res_data[sora_pkg::RES_SUMSQ] == '0) else $error("peak not cleared");
    a_alarm_above: assert property (sample_seen && sel == sora_pkg::SRC_ACCZ &&
        thr[1][sora_pkg::ALM_DIR_BIT] && mag > thr[1][sora_pkg::ALM_MAG_W-1:0] |=> alarm_act[1])
        else $error("alarm 2 missed above threshold");
    a_capture_start: assert property ($rose(alarm_act[0]) &&
        $past(alarm_control[sora_pkg::ALM_CAP_LSB]) |-> capture_start_o)
        else $error("capture not started");
    a_ind_route: assert property (alarm_act != '0 && $stable(alarm_control) &&
        alarm_control[2:0] == 3'h7 |-> gen_io_line_b_o && !gen_io_line_a_o)
        else $error("indicator on wrong line");

    c_read_frame:  cover property (rd_stb ##[1:200] frame_valid);
    c_alarm_cap:   cover property (capture_start_o);
    c_peak_clear:  cover property (peak_clr);
endmodule // sora_regs

// >>> hw/sora_spi_slave.sv
module sora_spi_slave #(
    parameter int unsigned FRAME_W = sora_pkg::FRAME_W
) (
    // clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               rstn_i,
    // serial pins
    input  wire logic               spi_sclk_i,
    input  wire logic               spi_cs_n_i,
    input  wire logic               spi_din_i,
    output logic                    spi_dout_o,
    output logic                    spi_dout_oe_n_o,
    // frame side
    input  wire logic [FRAME_W-1:0] tx_word_i,
    output logic                    frame_valid_o,
    output logic [FRAME_W-1:0]      frame_word_o
);
    localparam int CNT_W = $clog2(FRAME_W);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(FRAME_W - 1);

    logic [2:0]         sclk_s;
    logic [2:0]         cs_s;
    logic [1:0]         din_s;
    logic [CNT_W-1:0]   cnt;
    logic [FRAME_W-1:0] rx_sh;
    logic [FRAME_W-1:0] tx_sh;
    logic               rise;
    logic               active;
    logic               start;

    // two-stage synchronisers, third stage only for edges
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_s <= 3'h7;
            cs_s   <= 3'h7;
            din_s  <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], spi_sclk_i};
            cs_s   <= {cs_s[1:0], spi_cs_n_i};
            din_s  <= {din_s[0], spi_din_i};
        end
    end

    assign rise   = sclk_s[1] & ~sclk_s[2];
    assign active = ~cs_s[1];
    assign start  = ~cs_s[1] & cs_s[2];

    // input shift on rising clock, msb first
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt           <= '0;
            rx_sh         <= '0;
            frame_valid_o <= 1'b0;
            frame_word_o  <= '0;
        end else begin
            frame_valid_o <= 1'b0;
            if (!active) begin
                cnt <= '0;
            end else if (rise) begin
                rx_sh <= {rx_sh[FRAME_W-2:0], din_s[1]};
                if (cnt == LAST) begin
                    cnt           <= '0;
                    frame_valid_o <= 1'b1;
                    frame_word_o  <= {rx_sh[FRAME_W-2:0], din_s[1]};
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

    // output shift once the host has sampled a bit, loaded at select
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_sh           <= '0;
            spi_dout_oe_n_o <= 1'b1;
        end else begin
            spi_dout_oe_n_o <= cs_s[1];
            if (start) begin
                tx_sh <= tx_word_i;
            end else if (active && rise) begin
                tx_sh <= {tx_sh[FRAME_W-2:0], 1'b0};
            end
        end
    end

    assign spi_dout_o = tx_sh[FRAME_W-1];
endmodule // sora_spi_slave

// >>> verification/sora_host_model.sv
module sora_host_model (
    // serial pins
    output logic      spi_sclk_o,
    output logic      spi_cs_n_o,
    output logic      spi_din_o,
    input  wire logic spi_dout_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spi_sclk_o = 1'b1;
        spi_cs_n_o = 1'b1;
        spi_din_o  = 1'b0;
    end
    // one 16-bit frame, mode 3, msb first
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        spi_cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            #25 spi_sclk_o = 1'b0;
            spi_din_o = w[i];
            #25 spi_sclk_o = 1'b1;
            r[i] = spi_dout_i;
        end
        #25 spi_cs_n_o = 1'b1;
        spi_din_o = ~w[0];
        #30;
    endtask
endmodule // sora_host_model

// >>> verification/sora_regs_bench.sv
module sora_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i, rstn_i, sclk, cs_n, din, dout, sv, ext, io_a, io_b, cap;
    logic [9:0]  sup, ax, ay, az, aux, tmp, x;
    logic [15:0] diag, r;
    logic [31:0] seed = 32'hddc86f84;
    int          failures = 0;
    int          num_checks = 0;
    sora_host_model host (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_din_o(din), .spi_dout_i(dout));
    sora_regs #(.CAPT_DEPTH(64)) uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_din_i(din), .spi_dout_o(dout), .spi_dout_oe_n_o(), .sample_valid_i(sv),
        .supply_i(sup), .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az), .aux_i(aux), .temp_i(tmp),
        .diag_error_flags_i(diag), .ext_trigger_i(ext), .capt_rd_addr_i(6'h00), .capt_x_o(), .capt_y_o(),
        .capt_z_o(), .gen_io_line_a_o(io_a), .gen_io_line_b_o(io_b), .capture_start_o(cap));
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [15:0] word(input logic nd, input logic ea, input logic [9:0] d);
        return {nd, ea, 4'h0, d};
    endfunction
    task automatic rnd;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        host.xfer({1'b0, a, 8'h00}, d);
        host.xfer(16'h0000, d);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host.xfer({1'b1, a, v}, r);
    endtask
    task automatic smp(input logic [9:0] v);
        @(negedge clk_sys_i);
        rnd;
        {sup, ay, az} = seed[29:0];
        {aux, tmp} = seed[19:0];
        ax = v;
        sv = 1'b1;
        @(negedge clk_sys_i);
        sv = 1'b0;
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #200us;
        failures++;
        summarize;
    end
    initial begin
        {rstn_i, sv, ext, diag, sup, ax, ay, az, aux, tmp} = '0;
        repeat (2) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        rd(sora_pkg::OFF_THR1, r);
        chk(sora_pkg::THR_RST, r);
        rd(sora_pkg::OFF_ALM + 7'h01, r);
        chk(sora_pkg::ALM_RST, r);
        $display("reset values done");
        rnd;
        x = seed[9:0];
        smp(x);
        rd(sora_pkg::OFF_ACC_X, r);
        chk(word(1'b1, 1'b0, x), r);
        rd(sora_pkg::OFF_ACC_X, r);
        chk(word(1'b1, 1'b0, x), r);
        chk({6'h00, r[9:0]}, {6'h00, x});
        wr(sora_pkg::OFF_MISC, 8'h00);
        smp(10'h3ff);
        rd(sora_pkg::OFF_ACC_X + 7'h01, r);
        chk(word(1'b1, 1'b0, 10'h3ff), r);
        rd(sora_pkg::OFF_ACC_X, r);
        chk(word(1'b0, 1'b0, 10'h3ff), r);
        diag = 16'h0004;
        rd(sora_pkg::OFF_ACC_X, r);
        chk(word(1'b0, 1'b1, 10'h3ff), r);
        diag = 16'h0000;
        $display("new flag test done");
        wr(sora_pkg::OFF_THR1 + 7'h01, 8'h80);
        wr(sora_pkg::OFF_THR1, 8'h64);
        wr(sora_pkg::OFF_ALM + 7'h01, 8'h02);
        wr(sora_pkg::OFF_ALM, 8'h16);
        foreach (x[i]) begin
            smp(i[0] ? 10'd50 : 10'h338);
            repeat (1) @(negedge clk_sys_i);
            chk({13'h0, cap, io_a, io_b}, i[0] ? 16'h0000 : 16'h0006);
            if (i == 8) break;
        end
        $display("alarm test done");
        summarize;
    end
endmodule // sora_regs_bench
